/* File: logic/gpio_defs.svh */
// Register indices, field positions and reset values of the port block.
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
// Register indices; the byte address on the bus is four times the index.
`define IDX_DIR0 8'hb8
`define IDX_DIR1 8'hc1
`define IDX_DIR2 8'hc2
`define IDX_DIR3 8'hc3
`define IDX_DIR5 8'hc5
`define IDX_EDGE 8'hbf
`define IDX_DAT0 8'hd0
`define IDX_DAT1 8'hd1
`define IDX_DAT2 8'hd2
`define IDX_DAT3 8'hd3
`define IDX_DAT5 8'hd5
`define IDX_SEG 8'ha0
`define IDX_STAT 8'ha1
`define IDX_MASK 8'ha2
`define IDX_BITOP 8'ha3
// Implemented direction and latch bits of each port.
`define MASK_P0 8'h17
`define MASK_P1 8'h7f
`define MASK_P2 8'hff
`define MASK_P3 8'hff
`define MASK_P5 8'h10
`define PINS_P0 8'h1f
// Port slots: ports 0, 1, 2, 3 and 5 in that order.
`define NSLOT 5
`define SLOT_P0 3'h0
`define SLOT_P1 3'h1
`define SLOT_P2 3'h2
`define SLOT_P3 3'h3
`define SLOT_P5 3'h4
`define P0_RST_BIT 3
`define P0_OSC_BIT 4
`define NIB_W 4
`define NIB_PER_PORT 2
// Edge selector field and codes.
`define EDGE_LSB 3
`define EDGE_RST 2'h2
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define SEG_RST 3'h0
// Bit operation register fields.
`define BOP_SLOT_LSB 4
`define BOP_VAL 8
`define EXT_INTERRUPT_ZERO_BIT 0
`define EXT_INTERRUPT_ONE_BIT 1
`define ADDR_W 10
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

/* File: logic/gpio_pkg.sv */
// Types shared by the port block and its edge detector.
`include "gpio_defs.svh"
package gpio_pkg;
  // Oscillator pin option strapped at build time.
  typedef enum logic [1:0] {HCLK_4M, HCLK_12M, HCLK_RC, HCLK_NONE} hclk_t;
  // Register kinds found by the address decoder.
  typedef enum logic [2:0] {K_NONE, K_DIR, K_DATA, K_EDGE, K_SEG, K_STAT,
    K_MASK, K_BITOP} reg_kind_t;
  typedef struct packed {
    reg_kind_t kind;
    logic [2:0] slot;
  } reg_dec_t;
  typedef logic [`NSLOT-1:0][7:0] port_bus_t;
  // Edge detector state.
  typedef struct packed {
    logic armed;
    logic [1:0] prev;
  } edge_state_t;
  // Whole state of the port block.
  typedef struct packed {
    port_bus_t dir;
    port_bus_t latch;
    logic [1:0] edge_sel;
    logic [2:0] seg_sel;
    logic [1:0] stat;
    logic [1:0] mask;
    logic aw_have;
    logic [7:0] aw_idx;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    port_bus_t pad_out;
    port_bus_t pad_oe;
    logic ext_reset_n;
  } gpio_state_t;
endpackage : gpio_pkg

/* File: logic/edge_if.sv */
// Interface between the port block and its edge detector.
`timescale 1ns/1ps
interface edge_if;
  logic [1:0] level; // Pin levels of port 0 bits 0 and 1.
  logic [1:0] edge_sel; // Edge choice for the first pin.
  logic ev0; // One-cycle event on the first pin.
  logic ev1; // One-cycle event on the second pin.
  modport det (input level, input edge_sel, output ev0, output ev1);
  modport user (output level, output edge_sel, input ev0, input ev1);
endinterface : edge_if

/* File: logic/edge_detect.sv */
// Edge detector for the two external interrupt pins.
`timescale 1ns/1ps
`include "gpio_defs.svh"
module edge_detect
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  edge_if.det e
);
  edge_state_t st; // Registered state.
  edge_state_t nxt; // Next state.
  logic [1:0] rise; // Rising edges seen this cycle.
  logic [1:0] fall; // Falling edges seen this cycle.

  // The armed bit keeps the first sample after reset from looking like
  // an edge when the pin already rests high.
  always_comb
  begin
    nxt = st;
    nxt.armed = 1'b1;
    nxt.prev = e.level;
  end

  assign rise = {2{st.armed}} & ~st.prev & e.level;
  assign fall = {2{st.armed}} & st.prev & ~e.level;

  // First pin follows the selector; the reserved code gives no event.
  always_comb
  begin
    unique case (e.edge_sel)
      `EDGE_RISE: e.ev0 = rise[0];
      `EDGE_FALL: e.ev0 = fall[0];
      `EDGE_BOTH: e.ev0 = rise[0] | fall[0];
      default: e.ev0 = 1'b0;
    endcase
  end
  assign e.ev1 = fall[1];

  // Register the state.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= nxt;
  end
endmodule : edge_detect

/* File: logic/gpio_port_pin_sharing.sv */
// Port direction, pin sharing and external interrupt flags.
`timescale 1ns/1ps
`include "gpio_defs.svh"
module gpio_port_pin_sharing
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire port_bus_t pad_in,
  output port_bus_t pad_out,
  output port_bus_t pad_oe,
  input wire logic reset_pin_option,
  input wire hclk_t high_clk_option,
  input wire logic cpu_clk,
  input wire logic [15:0] lcd_segment_output,
  output logic ext_reset_n,
  output logic crystal_output_pin,
  output logic ext_ext_interrupt_zero_request,
  output logic ext_ext_interrupt_one_request,
  output logic irq
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Decodes a register index; shared by the read and write paths.
  function automatic reg_dec_t dec(input logic [7:0] idx);
    reg_dec_t d;
    d.kind = K_NONE;
    d.slot = `SLOT_P0;
    unique case (idx)
      `IDX_DIR0: d = '{K_DIR, `SLOT_P0};
      `IDX_DIR1: d = '{K_DIR, `SLOT_P1};
      `IDX_DIR2: d = '{K_DIR, `SLOT_P2};
      `IDX_DIR3: d = '{K_DIR, `SLOT_P3};
      `IDX_DIR5: d = '{K_DIR, `SLOT_P5};
      `IDX_DAT0: d = '{K_DATA, `SLOT_P0};
      `IDX_DAT1: d = '{K_DATA, `SLOT_P1};
      `IDX_DAT2: d = '{K_DATA, `SLOT_P2};
      `IDX_DAT3: d = '{K_DATA, `SLOT_P3};
      `IDX_DAT5: d = '{K_DATA, `SLOT_P5};
      `IDX_EDGE: d.kind = K_EDGE;
      `IDX_SEG: d.kind = K_SEG;
      `IDX_STAT: d.kind = K_STAT;
      `IDX_MASK: d.kind = K_MASK;
      `IDX_BITOP: d.kind = K_BITOP;
      default: d.kind = K_NONE;
    endcase
    return d;
  endfunction : dec

  // Implemented bits of a port; the rest ignore writes and read zero, save port 0 bit 3, which a data read shows.
  function automatic logic [7:0] pmask(input logic [2:0] slot);
    unique case (slot)
      `SLOT_P0: return `MASK_P0;
      `SLOT_P1: return `MASK_P1;
      `SLOT_P2: return `MASK_P2;
      `SLOT_P3: return `MASK_P3;
      `SLOT_P5: return `MASK_P5;
      default: return 8'h00;
    endcase
  endfunction : pmask

  // A nibble of port 2 or 3 belongs to the LCD while the selector is at
  // or below its rank; higher codes hand it to general use.
  function automatic logic seg_owned(input logic [2:0] sel,
    input logic [2:0] slot, input logic nib);
    logic [2:0] rank;
    rank = 3'((slot - `SLOT_P2) * `NIB_PER_PORT) + 3'(nib);
    if (slot != `SLOT_P2 && slot != `SLOT_P3)
      return 1'b0;
    return sel <= rank;
  endfunction : seg_owned

  // Segment numbers run opposite to pin numbers inside a port.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    return {<<{v}};
  endfunction : rev8

  // ---------------------------------------------------------------
  // State and edge detector
  // ---------------------------------------------------------------
  gpio_state_t st; // Registered state.
  gpio_state_t nxt; // Next state.
  reg_dec_t wr_d; // Decoded write target.
  reg_dec_t rd_d; // Decoded read target.
  logic wr_fire; // Address and data both held: write now.
  logic [7:0] rbyte; // Byte returned by a read.
  logic [7:0] pin_rd; // Pin or latch view of a data port.
  port_bus_t gen_out; // Pin drive before oscillator override.
  port_bus_t gen_oe; // Pin enable before oscillator override.
  port_bus_t pin_out; // Final pin drive.
  port_bus_t pin_oe; // Final pin enable.
  logic [2:0] bop_slot; // Port chosen by a bit operation.
  logic [2:0] bop_bit; // Bit chosen by a bit operation.
  edge_if eif ();

  assign eif.level = {pad_in[`SLOT_P0][`EXT_INTERRUPT_ONE_BIT],
    pad_in[`SLOT_P0][`EXT_INTERRUPT_ZERO_BIT]};
  assign eif.edge_sel = st.edge_sel;

  edge_detect u_edge (
    .mclk(mclk),
    .nrst(nrst),
    .e(eif)
  );

  // ---------------------------------------------------------------
  // Pin sharing
  // ---------------------------------------------------------------
  for (genvar gs = 0; gs < `NSLOT; gs++)
  begin : g_slot
    logic [`NIB_PER_PORT-1:0] own; // LCD owns the nibble.
    logic [7:0] own_m; // Ownership spread over bits.
    logic [7:0] lcd_b; // Segment data for this port.
    for (genvar gn = 0; gn < `NIB_PER_PORT; gn++)
    begin : g_nib
      assign own[gn] = seg_owned(st.seg_sel, 3'(gs), 1'(gn));
    end
    assign own_m = {{`NIB_W{own[1]}}, {`NIB_W{own[0]}}};
    assign lcd_b = (3'(gs) == `SLOT_P2) ? rev8(lcd_segment_output[15:8])
      : (3'(gs) == `SLOT_P3) ? rev8(lcd_segment_output[7:0]) : 8'h00;
    // Output pins drive their latch unless the LCD owns them.
    assign gen_out[gs] = (own_m & lcd_b) | (~own_m & st.latch[gs]);
    assign gen_oe[gs] = own_m | (st.dir[gs] & pmask(3'(gs)));
  end

  // The oscillator option overrides port 0 bit 4. The CPU clock passes
  // through a flop, so it leaves the pin one cycle late.
  always_comb
  begin
    pin_out = gen_out;
    pin_oe = gen_oe;
    pin_oe[`SLOT_P0][`P0_RST_BIT] = 1'b0;
    unique case (high_clk_option)
      HCLK_4M, HCLK_12M:
      begin
        pin_out[`SLOT_P0][`P0_OSC_BIT] = 1'b0;
        pin_oe[`SLOT_P0][`P0_OSC_BIT] = 1'b0;
      end
      HCLK_RC:
      begin
        pin_out[`SLOT_P0][`P0_OSC_BIT] = cpu_clk;
        pin_oe[`SLOT_P0][`P0_OSC_BIT] = 1'b1;
      end
      HCLK_NONE:
      begin
        pin_out[`SLOT_P0][`P0_OSC_BIT] = gen_out[`SLOT_P0][`P0_OSC_BIT];
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register bus and flags
  // ---------------------------------------------------------------
  assign bop_slot = st.wdata[`BOP_SLOT_LSB+2:`BOP_SLOT_LSB];
  assign bop_bit = st.wdata[2:0];

  // One process computes every next value of the block.
  always_comb
  begin
    nxt = st;
    rbyte = 8'h00;
    wr_d = dec(st.aw_idx);
    rd_d = dec(s_axi_araddr[`ADDR_W-1:2]);
    wr_fire = st.aw_have && st.w_have && !st.bvalid;
    pin_rd = (st.dir[rd_d.slot] & st.latch[rd_d.slot])
      | (~st.dir[rd_d.slot] & pad_in[rd_d.slot]);
    if (rd_d.slot == `SLOT_P0)
    begin
      pin_rd = pin_rd & `PINS_P0;
      // The reset pin reads as one while it serves as reset.
      if (reset_pin_option)
        pin_rd[`P0_RST_BIT] = 1'b1;
    end
    else
      pin_rd = pin_rd & pmask(rd_d.slot);
    // Address and data are captured in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt.aw_have = 1'b1;
      nxt.aw_idx = s_axi_awaddr[`ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt.w_have = 1'b1;
      nxt.wdata = s_axi_wdata;
      nxt.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      nxt.bvalid = 1'b0;
    // Registers are eight bits wide in byte lane 0, save the bit operation value at bit 8;
    // only the lane 0 strobe counts and a write without lane 0 changes nothing.
    if (wr_fire)
    begin
      nxt.aw_have = 1'b0;
      nxt.w_have = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = (wr_d.kind == K_NONE) ? `RESP_ERR : `RESP_OK;
      if (st.wstrb[0])
      begin
        unique case (wr_d.kind)
          K_DIR: nxt.dir[wr_d.slot] = st.wdata[7:0] & pmask(wr_d.slot);
          K_DATA: nxt.latch[wr_d.slot] = st.wdata[7:0] & pmask(wr_d.slot);
          K_EDGE: nxt.edge_sel = st.wdata[`EDGE_LSB+1:`EDGE_LSB];
          K_SEG: nxt.seg_sel = st.wdata[2:0];
          K_STAT: nxt.stat = st.stat & ~st.wdata[1:0];
          K_MASK: nxt.mask = st.wdata[1:0];
          K_BITOP:
          begin
            // Touches one direction bit and leaves its neighbours alone.
            if (bop_slot < 3'(`NSLOT))
              nxt.dir[bop_slot][bop_bit] = st.wdata[`BOP_VAL]
                & |(pmask(bop_slot) & (8'h01 << bop_bit));
          end
          K_NONE:
          begin
            nxt.bresp = `RESP_ERR;
          end
        endcase
      end
    end
    // Events set flags regardless of the mask, and win over a clear.
    if (eif.ev0)
      nxt.stat[`EXT_INTERRUPT_ZERO_BIT] = 1'b1;
    if (eif.ev1)
      nxt.stat[`EXT_INTERRUPT_ONE_BIT] = 1'b1;
    if (st.rvalid && s_axi_rready)
      nxt.rvalid = 1'b0;
    // Read data is taken when the address is accepted.
    if (s_axi_arvalid && s_axi_arready)
    begin
      unique case (rd_d.kind)
        K_DIR: rbyte = st.dir[rd_d.slot];
        K_DATA: rbyte = pin_rd;
        K_EDGE: rbyte = 8'(st.edge_sel) << `EDGE_LSB;
        K_SEG: rbyte = 8'(st.seg_sel);
        K_STAT: rbyte = 8'(st.stat);
        K_MASK: rbyte = 8'(st.mask);
        K_BITOP, K_NONE: rbyte = 8'h00;
      endcase
      nxt.rvalid = 1'b1;
      nxt.rdata = 32'(rbyte);
      nxt.rresp = (rd_d.kind == K_NONE) ? `RESP_ERR : `RESP_OK;
    end
    nxt.pad_out = pin_out;
    nxt.pad_oe = pin_oe;
    nxt.ext_reset_n = reset_pin_option ?
      pad_in[`SLOT_P0][`P0_RST_BIT] : 1'b1;
  end

  // Register the whole state; direction bits reset to input.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.edge_sel <= `EDGE_RST;
      st.seg_sel <= `SEG_RST;
      st.ext_reset_n <= 1'b1;
    end
    else
      st <= nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !st.aw_have && !st.bvalid;
  assign s_axi_wready = !st.w_have && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign pad_out = st.pad_out;
  assign pad_oe = st.pad_oe;
  assign ext_reset_n = st.ext_reset_n;
  assign crystal_output_pin = (high_clk_option == HCLK_4M)
    || (high_clk_option == HCLK_12M);
  assign ext_ext_interrupt_zero_request = st.stat[`EXT_INTERRUPT_ZERO_BIT];
  assign ext_ext_interrupt_one_request = st.stat[`EXT_INTERRUPT_ONE_BIT];
  // Only an unmasked flag raises the line.
  assign irq = |(st.stat & st.mask);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence fall1_s;
    pad_in[`SLOT_P0][`EXT_INTERRUPT_ONE_BIT] ##1 !pad_in[`SLOT_P0][`EXT_INTERRUPT_ONE_BIT];
  endsequence
  sequence rise0_s;
    !pad_in[`SLOT_P0][`EXT_INTERRUPT_ZERO_BIT] ##1
      (pad_in[`SLOT_P0][`EXT_INTERRUPT_ZERO_BIT] && st.edge_sel == `EDGE_RISE);
  endsequence

  AST_P1_DIR: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 pad_oe[`SLOT_P1] == $past(st.dir[`SLOT_P1]))
    else $error("port 1 enable does not follow direction");
  AST_P03_IN: assert property (@(posedge mclk) disable iff (!nrst)
    !pad_oe[`SLOT_P0][`P0_RST_BIT] && !st.dir[`SLOT_P0][`P0_RST_BIT])
    else $error("port 0 bit 3 driven");
  AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    (st.dir[`SLOT_P5] & ~`MASK_P5) == 8'h00)
    else $error("unimplemented direction bit set");
  AST_BITOP: assert property (@(posedge mclk) disable iff (!nrst)
    (wr_fire && wr_d.kind == K_BITOP && st.wstrb[0]
      && bop_slot == `SLOT_P1) |=>
      ((st.dir[`SLOT_P1] ^ $past(st.dir[`SLOT_P1]))
        & ~(8'h01 << $past(bop_bit))) == 8'h00)
    else $error("bit operation disturbed a neighbour");
  AST_RST_PIN: assert property (@(posedge mclk) disable iff (!nrst)
    reset_pin_option |=> ext_reset_n == $past(pad_in[`SLOT_P0]
      [`P0_RST_BIT]))
    else $error("reset pin not passed");
  AST_XTAL: assert property (@(posedge mclk) disable iff (!nrst)
    (high_clk_option == HCLK_4M) |=> !pad_oe[`SLOT_P0][`P0_OSC_BIT])
    else $error("crystal pin driven");
  AST_SEG3: assert property (@(posedge mclk) disable iff (!nrst)
    (st.seg_sel == 3'h3) |=> pad_oe[`SLOT_P2] == $past(st.dir[`SLOT_P2])
      && pad_oe[`SLOT_P3][3:0] == $past(st.dir[`SLOT_P3][3:0]))
    else $error("selector code 3 did not free pins");
  AST_SEG0: assert property (@(posedge mclk) disable iff (!nrst)
    (nrst && st.seg_sel == 3'h0) |=> pad_oe[`SLOT_P2] == 8'hff
      && pad_oe[`SLOT_P3] == 8'hff)
    else $error("segments not owning ports 2 and 3");
  AST_EXT_INTERRUPT_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    st.stat[`EXT_INTERRUPT_ZERO_BIT] == 1'b0 ##1 rise0_s |=> ext_ext_interrupt_zero_request)
    else $error("ext_interrupt_zero rising edge missed");
  AST_EXT_INTERRUPT_ONE: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 fall1_s |=> ext_ext_interrupt_one_request)
    else $error("ext_interrupt_one falling edge missed");
  AST_NO_VEC: assert property (@(posedge mclk) disable iff (!nrst)
    (eif.ev0 && st.mask == 2'h0 && !wr_fire) |=> ext_ext_interrupt_zero_request && !irq)
    else $error("flag missed or masked flag raised interrupt");
  AST_LATCH: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 pad_out[`SLOT_P1] == $past(st.latch[`SLOT_P1]))
    else $error("port 1 pin not driving its latch");
endmodule : gpio_port_pin_sharing

/* File: sim/board_model.sv */
// Board-side model of the pins that face the port block.
`timescale 1ns/1ps
module board_model
  import gpio_pkg::*;
(
  input wire port_bus_t pad_out,
  input wire port_bus_t pad_oe,
  input wire port_bus_t ext_lvl,
  output port_bus_t pad_in
);
  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // A wire shows the device level while it drives, else the board level.
  // The board never floats a pin, so no unknown reaches the sampler.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : board_model

/* File: sim/gpio_port_pin_sharing_tb.sv */
// Self-checking bench for the port block over its register bus.
`timescale 1ns/1ps
`include "gpio_defs.svh"
module gpio_port_pin_sharing_tb
  import gpio_pkg::*;
();
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk;
  logic nrst = 1'b0;
  logic [`ADDR_W-1:0] awaddr = '0;
  logic [`ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  port_bus_t pad_in, pad_out, pad_oe;
  port_bus_t ext_lvl = '1; // Board pulls every pin high.
  logic rst_opt = 1'b0;
  logic cpu_clk = 1'b0;
  hclk_t hclk = HCLK_NONE; // Plain pin use of the oscillator output.
  logic [15:0] lcd = 16'h00ff;
  logic ext_rst_n, xtal, irq0, irq1, irq;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd_d;
  logic [1:0] rsp;
  logic [7:0] idx [5] = '{`IDX_DIR0, `IDX_DIR1, `IDX_DIR2, `IDX_DIR3,
    `IDX_DIR5};
  logic [7:0] msk [5] = '{`MASK_P0, `MASK_P1, `MASK_P2, `MASK_P3,
    `MASK_P5};

  gpio_port_pin_sharing u_gpio_port_pin_sharing (.mclk(mclk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .reset_pin_option(rst_opt),
    .high_clk_option(hclk), .cpu_clk(cpu_clk), .lcd_segment_output(lcd),
    .ext_reset_n(ext_rst_n), .crystal_output_pin(xtal),
    .ext_ext_interrupt_zero_request(irq0), .ext_ext_interrupt_one_request(irq1), .irq(irq));

  board_model u_board_model (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_lvl(ext_lvl), .pad_in(pad_in));

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  // The 50 ns period gives the 20 MHz system clock.
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // The whole run needs about 260 cycles, so 8000 means a hang.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Compares one value; four-state equality keeps unknowns visible.
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Waits a fixed number of clock edges.
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask : w

  // Bus write; each channel drops valid only at its own handshake.
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= {i, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask : wr

  // Bus read; data and response are taken at the rvalid edge.
  task automatic rd(input logic [7:0] i);
    @(posedge mclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_d = rdata;
    rsp = rresp;
  endtask : rd

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    w(3);
    // Selector zero hands both wide ports to the segment driver.
    chk("seg_rst", {pad_out[3], pad_out[2], pad_oe[3], pad_oe[2]},
      32'hff00ffff);
    rd(`IDX_EDGE);
    chk("edge_rst", rd_d, 32'h10);
    // Each selector code frees one more nibble.
    for (int c = 0; c < 5; c++)
    begin
      wr(`IDX_SEG, 32'(c));
      w(3);
      chk("seg_oe2", pad_oe[2], {{4{c < 2}}, {4{c < 1}}});
      chk("seg_oe3", pad_oe[3], {{4{c < 4}}, {4{c < 3}}});
    end
    // Direction registers: reset, masked write-back and pin enables.
    for (int i = 0; i < 5; i++)
    begin
      rd(idx[i]);
      chk("dir_rst", rd_d, 0);
      wr(idx[i], 32'hff);
      rd(idx[i]);
      chk("dir_rd", rd_d, msk[i]);
      w(2);
      chk("dir_oe", pad_oe[i], msk[i]);
    end
    // Output drives the latch; input reads the board level.
    wr(`IDX_DAT1, 32'h55);
    w(2);
    chk("out_p1", pad_out[1], 32'h55);
    wr(`IDX_DIR1, 32'h0);
    ext_lvl[1] <= 8'h2a;
    w(2);
    rd(`IDX_DAT1);
    chk("in_p1", rd_d, 32'h2a);
    // Single-bit clear, then a set aimed at a missing bit.
    wr(`IDX_DIR1, 32'h7f);
    wr(`IDX_BITOP, 32'h012);
    wr(`IDX_BITOP, 32'h117);
    rd(`IDX_DIR1);
    chk("bitop", rd_d, 32'h7b);
    // An unmapped place refuses both directions.
    wr(8'h00, 32'hff);
    chk("bad_wr", rsp, `RESP_ERR);
    rd(8'h00);
    chk("bad_rd", {rsp, rd_d[29:0]}, {`RESP_ERR, 30'h0});
    // Edge codes 00 to 11 on the first pin; the second sees falls only.
    wr(`IDX_DIR0, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wr(`IDX_EDGE, 32'(c) << 3);
      wr(`IDX_STAT, 32'h3);
      ext_lvl[0][1:0] <= 2'b00;
      w(4);
      chk("ext_interrupt_zero_fall", irq0, 32'(c >= 2));
      chk("ext_interrupt_one_fall", irq1, 1);
      wr(`IDX_STAT, 32'h3);
      ext_lvl[0][1:0] <= 2'b11;
      w(4);
      chk("ext_interrupt_zero_rise", irq0, 32'(c % 2));
      chk("ext_interrupt_one_rise", irq1, 0);
    end
    // Flags set with the mask clear, yet no interrupt is raised.
    chk("irq_masked", {irq0, irq}, 2'b10);
    wr(`IDX_MASK, 32'h1);
    chk("irq_on", irq, 1);
    wr(`IDX_STAT, 32'h1);
    chk("irq_off", {irq0, irq}, 0);
    // Reset option turns the input-only pin into the reset input.
    rst_opt <= 1'b1;
    ext_lvl[0][3] <= 1'b0;
    w(3);
    chk("ext_rst_lo", ext_rst_n, 0);
    // The reset pin reads as one although the board holds it low.
    rd(`IDX_DAT0);
    chk("p03_rd", rd_d, 32'h1f);
    ext_lvl[0][3] <= 1'b1;
    w(3);
    chk("ext_rst_hi", ext_rst_n, 1);
    // Oscillator options claim the fifth pin of port 0, even as an output.
    wr(`IDX_DIR0, 32'h10);
    w(2);
    chk("p04_gpio", pad_oe[0][4], 1);
    hclk <= HCLK_4M;
    w(3);
    chk("xtal_4m", {xtal, pad_oe[0][4]}, 2'b10);
    hclk <= HCLK_12M;
    w(3);
    chk("xtal_12m", {xtal, pad_oe[0][4]}, 2'b10);
    hclk <= HCLK_RC;
    cpu_clk <= 1'b1;
    w(3);
    chk("cpuo_hi", {xtal, pad_oe[0][4], pad_out[0][4]}, 3'b011);
    cpu_clk <= 1'b0;
    w(3);
    chk("cpuo_lo", pad_out[0][4], 0);
    wrap_up();
  end
endmodule : gpio_port_pin_sharing_tb
